/* File: hw/ces_fifo.v */
// Purpose: Small FIFO with valid and ready on both sides and registered read data.
// Assumes: Read data appear in the cycle after the read handshake.
// Notes: Flush empties the FIFO in one cycle.
module ces_fifo #(
  parameter DW = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_flush,
  input wire i_in_valid,
  input wire [DW-1:0] i_in_data,
  output reg o_in_ready,
  output wire o_out_valid,
  input wire i_out_ready,
  output reg [DW-1:0] o_out_data
);
  localparam integer DEPTH_I = DEPTH;
  localparam integer LAST_I = DEPTH - 1;
  localparam [AW:0] FULL = DEPTH_I[AW:0];
  localparam [AW-1:0] LAST = LAST_I[AW-1:0];
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = i_in_valid & o_in_ready;
  wire pop = i_out_ready & o_out_valid;
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  // ----------------------------------------
  // Pointers and flags
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      o_in_ready <= 1'b1;
      o_out_data <= {DW{1'b0}};
    end else if (i_flush) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wp_q <= (wp_q == LAST) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == LAST) ? {AW{1'b0}} : rp_q + 1'b1;
        o_out_data <= mem[rp_q];
      end
      cnt_q <= cnt_d;
      o_in_ready <= (cnt_d != FULL);
    end
  end
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (push) begin
      mem[wp_q] <= i_in_data;
    end
  end
endmodule

/* File: hw/ces_reassembly_buffer_playout.v */
// Purpose: Reassembly buffer layout, fill accounting and playout start-up for one channel.
// Assumes: Cell octets arrive with start and end marks; framer request pins are asynchronous.
// Notes: Dropping the active input resets the whole channel.
`include "ces_regs.vh"
module ces_reassembly_buffer_playout #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_chan_active,
  input wire i_aal1,
  input wire i_sdt,
  input wire i_robust,
  input wire [5:0] i_cell_fill,
  input wire [5:0] i_num_ts,
  input wire [15:0] i_starv_ini,
  input wire [1:0] i_starv_sel,
  input wire [15:0] i_lsize,
  input wire i_cell_valid,
  input wire i_cell_sop,
  input wire i_cell_eop,
  input wire i_cell_pfmt,
  input wire [6:0] i_cell_ptr,
  input wire [7:0] i_cell_data,
  output wire o_cell_ready,
  input wire i_fr_req,
  input wire i_fr_sos,
  output reg o_fr_valid,
  output reg [7:0] o_fr_data,
  output reg o_underflow,
  output reg o_overflow,
  output reg o_wr_en,
  output reg [13:0] o_wr_addr,
  output reg [7:0] o_wr_data,
  output reg [3:0] o_cells_per_block,
  output reg [6:0] o_subblock_size,
  output reg [16:0] o_phys_size,
  output reg [15:0] o_fill_level
);
  localparam [2:0] ST_OFF = 3'd0;
  localparam [2:0] ST_UNDER = 3'd1;
  localparam [2:0] ST_INI = 3'd2;
  localparam [2:0] ST_SKIP = 3'd3;
  localparam [2:0] ST_WSOS = 3'd4;
  localparam [2:0] ST_PLAY = 3'd5;
  reg req_m_q, req_s_q, req_p_q, sos_m_q, sos_s_q;
  reg [5:0] thr1, thr2, thr3;
  reg [3:0] cpb;
  reg [6:0] sub_sz;
  reg [7:0] blk_q;
  reg [2:0] sub_q;
  reg [5:0] off_q;
  reg keep_q, got_p_q;
  reg [6:0] ptr_q;
  reg [15:0] cnt_q, pend_q, len_q;
  reg [15:0] cnt_d, pend_d, len_d, add;
  reg [2:0] st_q, st_d;
  reg [15:0] ini_q, ini_d;
  reg [6:0] skip_q, skip_d;
  reg pop, take, under;
  reg req_d1_q, take_q;
  reg [7:0] pat;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire req_pulse = req_s_q & ~req_p_q;
  wire avail = (cnt_q != 16'h0000) & fifo_out_valid;
  wire beat = i_cell_valid & o_cell_ready;
  wire [16:0] fill_new = {1'b0, cnt_q} + {1'b0, pend_q} + {11'h000, i_cell_fill};
  wire ovf_hit = fill_new > {1'b0, i_lsize};
  wire pass_sop = ~ovf_hit & (~i_sdt | got_p_q | i_cell_pfmt);
  wire keep = i_chan_active & (i_cell_sop ? pass_sop : keep_q);
  wire wr = beat & keep;
  wire [7:0] blk_last = {i_num_ts[4:0], 3'b000} - 8'h01;
  wire [13:0] wr_addr_d = {blk_q, 6'h00} + ({11'h000, sub_q} * {7'h00, sub_sz})
    + {8'h00, off_q};
  wire [16:0] phys_d = ({11'h000, i_num_ts} << `BLKS_PER_TS) * {11'h000, i_cell_fill}
    * {13'h0000, cpb};
  // ----------------------------------------
  // Framer request synchronisers
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_p_q <= 1'b0;
      sos_m_q <= 1'b0;
      sos_s_q <= 1'b0;
    end else begin
      req_m_q <= i_fr_req;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
      sos_m_q <= i_fr_sos;
      sos_s_q <= sos_m_q;
    end
  end
  // ----------------------------------------
  // Subblock layout
  // ----------------------------------------
  always @* begin
    if (!i_aal1) begin
      thr1 = `A0_THR1;
      thr2 = `A0_THR2;
      thr3 = `A0_THR3;
    end else if (!i_sdt) begin
      thr1 = `A1U_THR1;
      thr2 = `A1U_THR2;
      thr3 = `A1U_THR3;
    end else begin
      thr1 = `A1S_THR1;
      thr2 = `A1S_THR2;
      thr3 = `A1S_THR3;
    end
    if (i_cell_fill >= thr1) begin
      cpb = 4'd1;
      sub_sz = 7'd64;
    end else if (i_cell_fill >= thr2) begin
      cpb = 4'd2;
      sub_sz = 7'd32;
    end else if (i_cell_fill >= thr3) begin
      cpb = 4'd4;
      sub_sz = 7'd16;
    end else begin
      cpb = 4'd8;
      sub_sz = 7'd8;
    end
  end
  // ----------------------------------------
  // Fill accounting
  // ----------------------------------------
  always @* begin
    add = 16'h0000;
    pend_d = pend_q;
    len_d = len_q;
    if (wr) begin
      len_d = i_cell_sop ? 16'h0001 : len_q + 16'h0001;
      if (i_cell_sop && i_robust) begin
        add = pend_q;
        pend_d = 16'h0000;
      end
      if (i_cell_eop) begin
        if (i_robust) begin
          pend_d = len_d;
        end else begin
          add = add + len_d;
        end
        len_d = 16'h0000;
      end
    end
    cnt_d = cnt_q + add - {15'h0000, pop};
  end
  // ----------------------------------------
  // Cell write side
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      keep_q <= 1'b0;
      got_p_q <= 1'b0;
      ptr_q <= 7'h00;
      cnt_q <= 16'h0000;
      pend_q <= 16'h0000;
      len_q <= 16'h0000;
      blk_q <= 8'h00;
      sub_q <= 3'h0;
      off_q <= 6'h00;
      o_overflow <= 1'b0;
      o_wr_en <= 1'b0;
      o_wr_addr <= 14'h0000;
      o_wr_data <= 8'h00;
      o_cells_per_block <= 4'h1;
      o_subblock_size <= 7'h40;
      o_phys_size <= 17'h00000;
      o_fill_level <= 16'h0000;
    end else begin
      o_cells_per_block <= cpb;
      o_subblock_size <= sub_sz;
      o_phys_size <= phys_d;
      o_overflow <= i_chan_active & beat & i_cell_sop & ovf_hit;
      o_wr_en <= wr;
      o_wr_addr <= wr_addr_d;
      o_wr_data <= i_cell_data;
      // Activation is the channel reset, so the configuration must already be valid.
      if (!i_chan_active) begin
        keep_q <= 1'b0;
        got_p_q <= 1'b0;
        ptr_q <= 7'h00;
        cnt_q <= 16'h0000;
        pend_q <= 16'h0000;
        len_q <= 16'h0000;
        blk_q <= 8'h00;
        sub_q <= 3'h0;
        off_q <= 6'h00;
        o_fill_level <= 16'h0000;
      end else begin
        if (beat && i_cell_sop) begin
          keep_q <= pass_sop;
        end
        if (wr && i_cell_sop && i_sdt && i_cell_pfmt && !got_p_q) begin
          got_p_q <= 1'b1;
          ptr_q <= i_cell_ptr;
        end
        cnt_q <= cnt_d;
        pend_q <= pend_d;
        len_q <= len_d;
        o_fill_level <= cnt_d + pend_d + len_d;
        if (wr) begin
          off_q <= off_q + 6'h01;
          if (i_cell_eop) begin
            off_q <= 6'h00;
            if ({1'b0, sub_q} == cpb - 4'd1) begin
              sub_q <= 3'h0;
              blk_q <= (blk_q == blk_last) ? 8'h00 : blk_q + 8'h01;
            end else begin
              sub_q <= sub_q + 3'h1;
            end
          end
        end
      end
    end
  end
  // ----------------------------------------
  // Playout sequencer
  // ----------------------------------------
  always @* begin
    st_d = st_q;
    ini_d = ini_q;
    skip_d = skip_q;
    pop = 1'b0;
    take = 1'b0;
    under = 1'b0;
    case (st_q)
      ST_OFF: begin
        st_d = ST_UNDER;
      end
      ST_UNDER: begin
        under = req_pulse;
        if (cnt_q != 16'h0000) begin
          st_d = ST_INI;
          ini_d = i_starv_ini;
        end
      end
      ST_INI: begin
        if (req_pulse) begin
          if (ini_q == 16'h0000) begin
            skip_d = ptr_q;
            if (!i_sdt) begin
              st_d = ST_PLAY;
            end else if (ptr_q == 7'h00) begin
              st_d = ST_WSOS;
            end else begin
              st_d = ST_SKIP;
            end
          end else begin
            ini_d = ini_q - 16'h0001;
          end
        end
      end
      ST_SKIP: begin
        if (req_pulse && avail) begin
          pop = 1'b1;
          skip_d = skip_q - 7'h01;
          if (skip_q == 7'h01) begin
            st_d = ST_WSOS;
          end
        end
      end
      ST_WSOS: begin
        if (req_pulse && sos_s_q) begin
          st_d = ST_PLAY;
          pop = avail;
          take = avail;
          under = ~avail;
        end
      end
      ST_PLAY: begin
        if (req_pulse) begin
          pop = avail;
          take = avail;
          under = ~avail;
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
    if (!i_chan_active) begin
      st_d = ST_OFF;
      pop = 1'b0;
      take = 1'b0;
      under = 1'b0;
    end
  end
  always @* begin
    case (i_chan_active ? i_starv_sel : 2'b00)
      2'b00: pat = `STARV_PAT0;
      2'b01: pat = `STARV_PAT1;
      2'b10: pat = `STARV_PAT2;
      default: pat = `STARV_PAT3;
    endcase
  end
  // The FIFO returns read data one cycle late, so every answer waits one stage.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= ST_OFF;
      ini_q <= 16'h0000;
      skip_q <= 7'h00;
      req_d1_q <= 1'b0;
      take_q <= 1'b0;
      o_fr_valid <= 1'b0;
      o_fr_data <= 8'h00;
      o_underflow <= 1'b0;
    end else begin
      st_q <= st_d;
      ini_q <= ini_d;
      skip_q <= skip_d;
      req_d1_q <= req_pulse;
      take_q <= take;
      o_fr_valid <= req_d1_q;
      if (req_d1_q) begin
        o_fr_data <= take_q ? fifo_out_data : pat;
      end
      if (under) begin
        o_underflow <= 1'b1;
      end else if (take || !i_chan_active) begin
        o_underflow <= 1'b0;
      end
    end
  end
  // Robust mode needs a FIFO deeper than one cell, or the held cell can block the writer.
  ces_fifo #(
    .DW(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_flush(~i_chan_active),
    .i_in_valid(i_cell_valid & keep),
    .i_in_data(i_cell_data),
    .o_in_ready(o_cell_ready),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_out_data)
  );
endmodule

/* File: hw/ces_regs.vh */
// Purpose: Constants for the circuit-emulation reassembly buffer and its playout start-up.
// Assumes: One channel per instance; configuration ports are static while the channel is active.
// Notes: Thresholds are the lowest cell filling of each subblock band.
// Behaviour
// - Split each 64-octet block into one-cell subblocks, sized automatically from configuration.
// - AAL0 bands: 33-48 one, 17-32 two, 9-16 four, 4-8 eight cells.
// - AAL1 unstructured bands: 32-47 one, 16-31 two, 8-15 four, 4-7 eight.
// - AAL1 structured bands: 31-47 one, 15-30 two, 7-14 four, 4-6 eight.
// - Physical size is N times 8 blocks times filling times cells per block.
// - Starvation octets of an active channel carry the selected pattern; an inactive channel answers with pattern 0 (ff).
// - Logical size is the limit; a cell exceeding it is an overflow.
// - Unstructured: no cell in buffer means underflow and starvation octets.
// - Unstructured: after first cell send initial count plus one starvation octets.
// - Structured: stay in underflow until the first pointer-format cell is accepted.
// - Structured: then send initial count plus one starvation octets.
// - Structured: discard pointer-many octets, one starvation octet for each.
// - Structured: keep sending starvation until the port start of structure.
// - From port start of structure, play buffered octets with structures aligned.
// - Robust algorithm holds each cell provisionally until the next cell arrives.
// - Fast algorithm commits each accepted cell immediately.
`ifndef CES_REGS_VH
`define CES_REGS_VH
`define BLKS_PER_TS 3
`define A0_THR1 6'd33
`define A0_THR2 6'd17
`define A0_THR3 6'd9
`define A1U_THR1 6'd32
`define A1U_THR2 6'd16
`define A1U_THR3 6'd8
`define A1S_THR1 6'd31
`define A1S_THR2 6'd15
`define A1S_THR3 6'd7
`define STARV_PAT0 8'hff
`define STARV_PAT1 8'h7f
`define STARV_PAT2 8'h00
`define STARV_PAT3 8'hd5
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

/* File: tb/ces_framer_model.sv */
// Purpose: Framer transmit side that requests octets and collects the answers.
// Assumes: Requests are two cycles high and at least four low, set at the falling edge.
// Notes: Start of structure rides on one chosen request only; slow mode widens the gaps.
module ces_framer_model (
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic i_slow,
  input wire logic [7:0] i_sos_at,
  input wire logic i_fr_valid,
  input wire logic [7:0] i_fr_data,
  output logic o_fr_req,
  output logic o_fr_sos
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  int req_n;
  initial begin
    o_fr_req = 1'b0;
    o_fr_sos = 1'b0;
    req_n = 0;
    forever begin
      @(negedge i_core_clk);
      if (i_run) begin
        o_fr_req = 1'b1;
        o_fr_sos = (req_n == int'(i_sos_at));
        req_n++;
        repeat (2) @(negedge i_core_clk);
        o_fr_req = 1'b0;
        o_fr_sos = 1'b0;
        repeat (i_slow ? 12 : 3) @(negedge i_core_clk);
      end else begin
        req_n = 0;
      end
    end
  end
  always @(posedge i_core_clk) begin
    if (i_fr_valid === 1'b1) got_q.push_back(i_fr_data);
  end
endmodule

/* File: tb/ces_reassembly_buffer_playout_chk.sv */
// Purpose: Port checks for the reassembly buffer and its playout.
// Assumes: Configuration is static while cells or requests are in flight.
// Notes: Band checks look one cycle after the inputs they follow.
module ces_reassembly_buffer_playout_chk #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_chan_active,
  input wire i_aal1,
  input wire i_sdt,
  input wire [5:0] i_cell_fill,
  input wire [5:0] i_num_ts,
  input wire [1:0] i_starv_sel,
  input wire i_cell_valid,
  input wire i_cell_sop,
  input wire [7:0] i_cell_data,
  input wire o_cell_ready,
  input wire i_fr_req,
  input wire o_fr_valid,
  input wire [7:0] o_fr_data,
  input wire o_underflow,
  input wire o_overflow,
  input wire o_wr_en,
  input wire [13:0] o_wr_addr,
  input wire [7:0] o_wr_data,
  input wire [3:0] o_cells_per_block,
  input wire [6:0] o_subblock_size,
  input wire [16:0] o_phys_size
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  function automatic logic [7:0] pat(input logic [1:0] s);
    return s == 2'd0 ? 8'hff : s == 2'd1 ? 8'h7f : s == 2'd2 ? 8'h00 : 8'hd5;
  endfunction
  a_sub_times_cpb: assert property (o_cells_per_block * o_subblock_size == 11'd64)
    else $error("subblock split wrong");
  a_sub_start_aligned: assert property (o_wr_en && $past(i_cell_sop) |->
    o_wr_addr % o_subblock_size == 14'd0) else $error("cell start not on subblock");
  a_aal0_eight_band: assert property (!i_aal1 && i_cell_fill inside {[4:8]} |=>
    o_cells_per_block == 4'd8) else $error("aal0 band wrong");
  a_aal1u_two_band: assert property (i_aal1 && !i_sdt && i_cell_fill inside {[16:31]} |=>
    o_cells_per_block == 4'd2) else $error("aal1 band wrong");
  a_aal1s_four_band: assert property (i_aal1 && i_sdt && i_cell_fill inside {[7:14]} |=>
    o_cells_per_block == 4'd4) else $error("aal1 sdt band wrong");
  a_phys_size_calc: assert property (1'b1 |=> o_phys_size ==
    17'($past(i_num_ts) * 8 * $past(i_cell_fill) * o_cells_per_block)) else $error("size wrong");
  a_starv_octet_pat: assert property (i_chan_active && o_fr_valid && o_underflow &&
    $past(o_underflow) |-> o_fr_data == pat(i_starv_sel)) else $error("pattern wrong");
  a_ovf_at_sop: assert property (o_overflow |-> $past(i_cell_valid && i_cell_sop)
    && !o_wr_en) else $error("overflow not at cell start");
  a_wr_mirror: assert property (o_wr_en |-> $past(i_cell_valid && o_cell_ready) &&
    o_wr_data == $past(i_cell_data)) else $error("write not from taken octet");
  a_req_answered: assert property ($rose(i_fr_req) |-> ##[2:8] o_fr_valid)
    else $error("request unanswered");
  c_overflow: cover property (o_overflow);
  c_cell_start: cover property (o_wr_en && $past(i_cell_sop));
  c_data_octet: cover property (o_fr_valid && !o_underflow);
endmodule
bind ces_reassembly_buffer_playout ces_reassembly_buffer_playout_chk #(.DEPTH(DEPTH), .AW(AW))
  u_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_chan_active(i_chan_active),
  .i_aal1(i_aal1), .i_sdt(i_sdt), .i_cell_fill(i_cell_fill), .i_num_ts(i_num_ts),
  .i_starv_sel(i_starv_sel), .i_cell_valid(i_cell_valid), .i_cell_sop(i_cell_sop),
  .i_cell_data(i_cell_data), .o_cell_ready(o_cell_ready), .i_fr_req(i_fr_req),
  .o_fr_valid(o_fr_valid), .o_fr_data(o_fr_data), .o_underflow(o_underflow),
  .o_overflow(o_overflow), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
  .o_cells_per_block(o_cells_per_block), .o_subblock_size(o_subblock_size),
  .o_phys_size(o_phys_size));

/* File: tb/ces_reassembly_buffer_playout_tb_top.sv */
// Purpose: Self-checking bench for the reassembly buffer and playout start-up.
// Assumes: One channel with two timeslots; the framer model requests octets on demand.
// Notes: Each activation first holds the channel inactive for 250 us, which dominates run time.
module ces_reassembly_buffer_playout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_resetn, i_chan_active, i_aal1, i_sdt, i_robust, i_cell_valid, i_cell_sop, i_cell_eop;
  logic i_cell_pfmt, o_cell_ready, i_fr_req, i_fr_sos, o_fr_valid, o_underflow, o_overflow;
  logic o_wr_en, run, slow;
  logic [5:0] i_cell_fill, i_num_ts;
  logic [15:0] i_starv_ini, i_lsize, o_fill_level;
  logic [1:0] i_starv_sel;
  logic [6:0] i_cell_ptr, o_subblock_size;
  logic [7:0] i_cell_data, o_fr_data, o_wr_data, sos_at;
  logic [13:0] o_wr_addr;
  logic [3:0] o_cells_per_block;
  logic [16:0] o_phys_size;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int check_count = 0;
  int ovf_count = 0;
  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_overflow === 1'b1) ovf_count <= ovf_count + 1;
  ces_reassembly_buffer_playout u_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_chan_active(i_chan_active), .i_aal1(i_aal1), .i_sdt(i_sdt), .i_robust(i_robust),
    .i_cell_fill(i_cell_fill), .i_num_ts(i_num_ts), .i_starv_ini(i_starv_ini),
    .i_starv_sel(i_starv_sel), .i_lsize(i_lsize), .i_cell_valid(i_cell_valid),
    .i_cell_sop(i_cell_sop), .i_cell_eop(i_cell_eop), .i_cell_pfmt(i_cell_pfmt),
    .i_cell_ptr(i_cell_ptr), .i_cell_data(i_cell_data), .o_cell_ready(o_cell_ready),
    .i_fr_req(i_fr_req), .i_fr_sos(i_fr_sos), .o_fr_valid(o_fr_valid), .o_fr_data(o_fr_data),
    .o_underflow(o_underflow), .o_overflow(o_overflow), .o_wr_en(o_wr_en),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_cells_per_block(o_cells_per_block),
    .o_subblock_size(o_subblock_size), .o_phys_size(o_phys_size), .o_fill_level(o_fill_level));
  ces_framer_model u_frm (.i_core_clk(i_core_clk), .i_run(run), .i_slow(slow), .i_sos_at(sos_at),
    .i_fr_valid(o_fr_valid), .i_fr_data(o_fr_data), .o_fr_req(i_fr_req), .o_fr_sos(i_fr_sos));
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic send_cell(input logic p, input logic [6:0] ptr, input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) begin
      @(negedge i_core_clk);
      i_cell_valid = 1'b1;
      i_cell_sop = (k == 0);
      i_cell_eop = (k == n - 1);
      i_cell_pfmt = p;
      i_cell_ptr = ptr;
      i_cell_data = b + 8'(k);
      @(posedge i_core_clk);
      while (o_cell_ready !== 1'b1) @(posedge i_core_clk);
    end
    @(negedge i_core_clk);
    i_cell_valid = 1'b0;
    repeat (20) @(negedge i_core_clk);
  endtask
  task automatic activate(input logic a, s, r, input logic [5:0] f, input logic [1:0] sl,
    input logic [15:0] ini, lz);
    @(negedge i_core_clk);
    i_chan_active = 1'b0;
    i_aal1 = a;
    i_sdt = s;
    i_robust = r;
    i_cell_fill = f;
    i_starv_sel = sl;
    i_starv_ini = ini;
    i_lsize = lz;
    repeat (31250) @(negedge i_core_clk);
    i_chan_active = 1'b1;
    repeat (4) @(negedge i_core_clk);
  endtask
  task automatic play(input int n);
    u_frm.got_q.delete();
    run = 1'b1;
    for (int w = 0; w < 3000 && u_frm.got_q.size() < n; w++) @(negedge i_core_clk);
    run = 1'b0;
    repeat (20) @(negedge i_core_clk);
  endtask
  task automatic mk(input int np, input logic [7:0] p, b, input int nd, nt);
    exp_q.delete();
    repeat (np) exp_q.push_back(p);
    for (int k = 0; k < nd; k++) exp_q.push_back(b + 8'(k));
    repeat (nt) exp_q.push_back(p);
  endtask
  task automatic cmp_q();
    foreach (exp_q[k]) chk("octet", exp_q[k], u_frm.got_q[k]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bands();
    int lo[3][4] = '{'{33, 17, 9, 4}, '{32, 16, 8, 4}, '{31, 15, 7, 4}};
    int hi[3][4] = '{'{48, 32, 16, 8}, '{47, 31, 15, 7}, '{47, 30, 14, 6}};
    for (int m = 0; m < 3; m++) begin
      for (int b = 0; b < 8; b++) begin
        @(negedge i_core_clk);
        i_aal1 = (m > 0);
        i_sdt = (m == 2);
        i_cell_fill = 6'(b[0] ? hi[m][b / 2] : lo[m][b / 2]);
        repeat (2) @(negedge i_core_clk);
        chk("cells per block", 17'(1 << (b / 2)), o_cells_per_block);
        chk("subblock size", 17'(64 >> (b / 2)), o_subblock_size);
        chk("phys size", 17'(16 * int'(i_cell_fill) * (1 << (b / 2))), o_phys_size);
      end
    end
  endtask
  task automatic t_unstr();
    int ovf0;
    activate(1'b0, 1'b0, 1'b0, 6'd8, 2'd3, 16'd3, 16'd12);
    play(4);
    chk("underflow", 1'b1, o_underflow);
    mk(4, 8'hd5, 8'h00, 0, 0);
    cmp_q();
    ovf0 = ovf_count;
    send_cell(1'b0, 7'd0, 8, 8'h10);
    send_cell(1'b0, 7'd0, 8, 8'h20);
    chk("overflow", 17'd1, 17'(ovf_count - ovf0));
    chk("fill level", 16'd8, o_fill_level);
    play(14);
    mk(4, 8'hd5, 8'h10, 8, 2);
    cmp_q();
    chk("underflow", 1'b1, o_underflow);
  endtask
  task automatic t_struct();
    activate(1'b1, 1'b1, 1'b0, 6'd8, 2'd1, 16'd1, 16'd40);
    send_cell(1'b0, 7'd0, 8, 8'h30);
    chk("fill level", 16'd0, o_fill_level);
    send_cell(1'b1, 7'd2, 8, 8'h40);
    sos_at = 8'd9;
    slow = 1'b1;
    play(16);
    mk(9, 8'h7f, 8'h42, 6, 1);
    cmp_q();
    sos_at = 8'hff;
    slow = 1'b0;
  endtask
  task automatic t_robust();
    activate(1'b0, 1'b0, 1'b1, 6'd7, 2'd2, 16'd0, 16'd40);
    send_cell(1'b0, 7'd0, 7, 8'h50);
    chk("fill level", 16'd7, o_fill_level);
    play(2);
    mk(2, 8'h00, 8'h00, 0, 0);
    cmp_q();
    chk("underflow", 1'b1, o_underflow);
    send_cell(1'b0, 7'd0, 7, 8'h60);
    chk("fill level", 16'd14, o_fill_level);
    play(9);
    mk(1, 8'h00, 8'h50, 7, 1);
    cmp_q();
  endtask
  initial begin
    {i_resetn, i_chan_active, i_aal1, i_sdt, i_robust, i_cell_valid} = '0;
    {i_cell_sop, i_cell_eop, i_cell_pfmt, run, slow} = '0;
    {i_cell_ptr, i_cell_data, i_starv_sel, i_starv_ini, i_lsize} = '0;
    i_cell_fill = 6'd8;
    i_num_ts = 6'd2;
    sos_at = 8'hff;
    repeat (8) @(negedge i_core_clk);
    chk("subblock size", 17'd64, o_subblock_size);
    i_resetn = 1'b1;
    t_bands();
    t_unstr();
    t_struct();
    t_robust();
    stop_test();
  end
  initial begin
    repeat (99000) @(posedge i_core_clk);
    bad_count++;
    $display("unexpected run length: expected done seen timeout");
    stop_test();
  end
endmodule
